// *** rtl/mvip_regs.svh ***
// constants of the multilevel vector interrupt priority unit
`ifndef MVIP_REGS_SVH
`define MVIP_REGS_SVH
`define MVIP_NUM_SRC      18
`define MVIP_NUM_VEC      10
`define MVIP_VEC_BASE     8'h03
`define MVIP_VEC_STEP     8'h08
`define MVIP_SVC_RESET    3'h0
`define MVIP_IDX_RESET    4'h0
`endif

// *** rtl/mvip_pkg.sv ***
// types and source map of the multilevel vector interrupt priority unit
`include "mvip_regs.svh"
package mvip_pkg;

  typedef enum logic [1:0]
  {
    LvlNone = 2'h0,
    LvlLow  = 2'h1,
    LvlHigh = 2'h2,
    LvlTop  = 2'h3
  } mvip_level_t;

  typedef enum logic
  {
    MvipIdle  = 1'h0,
    MvipOffer = 1'h1
  } mvip_fsm_t;

  typedef struct packed
  {
    mvip_fsm_t   fsm;
    logic [2:0]  inService;
    logic [3:0]  reqIdx;
    mvip_level_t reqLvl;
  } mvip_state_t;

  // source number to vector index
  function automatic logic [3:0] mvipVecOfSrc(input logic [4:0] s);
    logic [3:0] v;
    v = 4'h0;
    case (s)
      5'h00: v = 4'h0;
      5'h01: v = 4'h1;
      5'h02, 5'h03, 5'h04: v = 4'h2;
      5'h05, 5'h06: v = 4'h3;
      5'h07: v = 4'h4;
      5'h08, 5'h09: v = 4'h5;
      5'h0A, 5'h0B: v = 4'h6;
      5'h0C, 5'h0D: v = 4'h7;
      5'h0E, 5'h0F, 5'h10: v = 4'h8;
      5'h11: v = 4'h9;
      default: v = 4'h0;
    endcase
    return v;
  endfunction

  // the upper choice is highest for the two external vectors, else high
  function automatic mvip_level_t mvipVecLevel(input logic [3:0] v,
                                               input logic sel);
    mvip_level_t l;
    l = LvlLow;
    if (sel)
      l = (v < 4'h2) ? LvlTop : LvlHigh;
    return l;
  endfunction

endpackage

// *** rtl/mvip_ctrl.sv ***
// interrupt priority and vectoring unit facing the core sequencer
//
// Function
// - three levels exist: low, high, highest, ordered highest > high > low
// - in service, only strictly higher levels may be offered and nest
// - among pending vectors, the highest level is granted first
// - at equal level, the smallest vector address wins
// - eighteen sources merge onto ten vectors
// - vectors 03H and 0BH take highest or low; others high or low
// - remaining vectors serve their fixed source groups in address order
`timescale 1ns/1ps
module mvip_ctrl
  import mvip_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic [`MVIP_NUM_SRC-1:0] srcEnable,
  input  wire logic [`MVIP_NUM_SRC-1:0] srcPending,
  input  wire logic [`MVIP_NUM_VEC-1:0] levelSel,
  input  wire logic                     intAck,
  input  wire logic                     intReturn,
  output logic                          intReq,
  output logic [7:0]                    intVecAddr,
  output logic [3:0]                    intVecIndex,
  output logic [1:0]                    intLevel,
  output logic [1:0]                    serviceLevel
);

  // ==========================================================
  // source merge
  logic [`MVIP_NUM_VEC-1:0] vecReq;
  mvip_level_t              vecLvl [`MVIP_NUM_VEC];

  genvar gv;
  generate
    for (gv = 0; gv < `MVIP_NUM_VEC; gv++)
    begin : g_vec
      always_comb
      begin
        vecReq[gv] = 1'b0;
        for (int s = 0; s < `MVIP_NUM_SRC; s++)
          if (mvipVecOfSrc(5'(s)) == 4'(gv))
            vecReq[gv] = vecReq[gv] | (srcEnable[s] & srcPending[s]);
        vecLvl[gv] = mvipVecLevel(4'(gv), levelSel[gv]);
      end
    end
  endgenerate

  // ==========================================================
  // state
  mvip_state_t st_q;
  mvip_state_t st_d;

  function automatic mvip_level_t topOf(input logic [2:0] svc);
    mvip_level_t l;
    l = LvlNone;
    if (svc[2])
      l = LvlTop;
    else if (svc[1])
      l = LvlHigh;
    else if (svc[0])
      l = LvlLow;
    return l;
  endfunction

  logic        winValid;
  logic [3:0]  winIdx;
  mvip_level_t winLvl;
  logic [2:0]  svcNext;
  mvip_level_t curLvl;

  always_comb
  begin
    st_d    = st_q;
    svcNext = st_q.inService;
    // a return retires the innermost level first
    if (intReturn)
    begin
      case (topOf(svcNext))
        LvlTop:  svcNext[2] = 1'b0;
        LvlHigh: svcNext[1] = 1'b0;
        LvlLow:  svcNext[0] = 1'b0;
        default: svcNext = svcNext;
      endcase
    end
    if (intAck && st_q.fsm == MvipOffer)
    begin
      case (st_q.reqLvl)
        LvlTop:  svcNext[2] = 1'b1;
        LvlHigh: svcNext[1] = 1'b1;
        LvlLow:  svcNext[0] = 1'b1;
        default: svcNext = svcNext;
      endcase
    end
    curLvl   = topOf(svcNext);
    winValid = 1'b0;
    winIdx   = 4'h0;
    winLvl   = LvlNone;
    // descending scan with >= leaves the smallest index at a tie
    for (int v = `MVIP_NUM_VEC - 1; v >= 0; v--)
      if (vecReq[v] && vecLvl[v] >= winLvl && vecLvl[v] > curLvl)
      begin
        winValid = 1'b1;
        winIdx   = 4'(v);
        winLvl   = vecLvl[v];
      end
    st_d.inService = svcNext;
    // the offer is recomputed every cycle so a newly raised higher
    // request replaces a stale one before the core takes it
    case (st_q.fsm)
      MvipIdle,
      MvipOffer:
      begin
        st_d.fsm    = winValid ? MvipOffer : MvipIdle;
        st_d.reqIdx = winValid ? winIdx : st_q.reqIdx;
        st_d.reqLvl = winValid ? winLvl : LvlNone;
      end
      default:
      begin
        st_d.fsm = MvipIdle;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q.fsm       <= MvipIdle;
      st_q.inService <= `MVIP_SVC_RESET;
      st_q.reqIdx    <= `MVIP_IDX_RESET;
      st_q.reqLvl    <= LvlNone;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs
  assign intReq       = (st_q.fsm == MvipOffer);
  assign intVecIndex  = st_q.reqIdx;
  assign intVecAddr   = `MVIP_VEC_BASE + {st_q.reqIdx, 3'h0};
  assign intLevel     = st_q.reqLvl;
  assign serviceLevel = topOf(st_q.inService);

  // ==========================================================
  // checks
  logic betterExists;
  always_comb
  begin
    betterExists = 1'b0;
    for (int v = 0; v < `MVIP_NUM_VEC; v++)
      if (vecReq[v] && (vecLvl[v] > winLvl ||
          (vecLvl[v] == winLvl && 4'(v) < winIdx)))
        betterExists = 1'b1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_strictly_higher: assert property (
    intReq |-> intLevel > serviceLevel)
    else $error("offered level not above level in service");

  chk_top_blocks_all: assert property (
    serviceLevel == 2'h3 && !intReturn |=> !intReq)
    else $error("request offered while highest level in service");

  chk_ack_nests: assert property (
    intAck && intReq && !intReturn |=> serviceLevel == $past(intLevel))
    else $error("accepted level not recorded as in service");

  chk_ack_withdraws: assert property (
    intAck && intReq && !intReturn |=> !intReq ||
      intLevel > $past(intLevel))
    else $error("same offer kept after acceptance");

  chk_vector_addr: assert property (
    intReq |-> intVecAddr == 8'h03 + 8'h08 * {4'h0, intVecIndex})
    else $error("vector address does not match index");

  chk_fixed_levels: assert property (
    intReq && intVecIndex > 4'h1 |-> intLevel inside {2'h1, 2'h2})
    else $error("shared vector offered at highest level");

  chk_enable_gate: assert property (
    (srcEnable & srcPending) == 18'h0 |=> !intReq)
    else $error("request offered without enabled pending source");

  chk_winner_best: assert property (
    winValid |-> !betterExists)
    else $error("granted vector is not the best candidate");

  chk_source_map: assert property (
    srcEnable == 18'h10 && srcPending == 18'h10 &&
      serviceLevel == 2'h0 && !intAck |=> intReq && intVecIndex == 4'h2)
    else $error("source four not mapped to third vector");

  cov_nest_top: cover property (
    intAck && intReq && intLevel == 2'h3 && serviceLevel == 2'h1);
  cov_same_level_tie: cover property (
    winValid && vecReq[2] && vecReq[3] && vecLvl[2] == vecLvl[3]);
  cov_refused: cover property (
    serviceLevel == 2'h2 && |vecReq && !intReq);
  cov_return: cover property (intReturn && serviceLevel == 2'h2);

endmodule // mvip_ctrl

// *** tb/mvip_core_model.sv ***
// behavioural core sequencer that accepts offers and returns
`timescale 1ns/1ps
module mvip_core_model
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic intReq,
  input  wire logic ackCmd,
  input  wire logic retCmd,
  output logic      intAck,
  output logic      intReturn
);
  // a real core never acknowledges without a standing offer
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      intAck    <= 1'b0;
      intReturn <= 1'b0;
    end
    else
    begin
      intAck    <= ackCmd & intReq;
      intReturn <= retCmd;
    end
endmodule // mvip_core_model

// *** tb/mvip_ctrl_bench.sv ***
// self-checking bench of the interrupt priority unit
`timescale 1ns/1ps
module mvip_ctrl_bench;
  typedef struct packed
  {
    logic [17:0] en;
    logic [17:0] pd;
    logic [9:0]  sel;
    logic        req;
    logic [3:0]  idx;
    logic [1:0]  lvl;
  } mvip_row_t;
  localparam mvip_row_t Rows [6] = '{
    '{18'h3FFFF, 18'h00002, 10'h002, 1'b1, 4'h1, 2'h3},
    '{18'h3FFFF, 18'h20004, 10'h004, 1'b1, 4'h2, 2'h2},
    '{18'h3FFFF, 18'h08400, 10'h000, 1'b1, 4'h6, 2'h1},
    '{18'h20000, 18'h20001, 10'h000, 1'b1, 4'h9, 2'h1},
    '{18'h3FFFF, 18'h00201, 10'h020, 1'b1, 4'h5, 2'h2},
    '{18'h3FFFF, 18'h00000, 10'h000, 1'b0, 4'h0, 2'h0}};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [17:0] srcEnable = 18'h00000;
  logic [17:0] srcPending = 18'h00000;
  logic [9:0] levelSel = 10'h000;
  logic ackCmd = 1'b0;
  logic retCmd = 1'b0;
  logic intAck, intReturn, intReq;
  logic [7:0] intVecAddr;
  logic [3:0] intVecIndex;
  logic [1:0] intLevel, serviceLevel;
  int mismatches = 0;
  int numChecks = 0;
  int cycles = 0;
  always #50 clk = ~clk;
  mvip_ctrl u_mvip_ctrl (.clk(clk), .reset_n(reset_n),
    .srcEnable(srcEnable), .srcPending(srcPending), .levelSel(levelSel),
    .intAck(intAck), .intReturn(intReturn), .intReq(intReq),
    .intVecAddr(intVecAddr), .intVecIndex(intVecIndex),
    .intLevel(intLevel), .serviceLevel(serviceLevel));
  mvip_core_model u_mvip_core_model (.clk(clk), .reset_n(reset_n),
    .intReq(intReq), .ackCmd(ackCmd), .retCmd(retCmd),
    .intAck(intAck), .intReturn(intReturn));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // a hung handshake must still reach the verdict
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    numChecks++;
    if (s !== e)
    begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic offer(input logic r, input logic [3:0] i,
                       input logic [1:0] l);
    chk(8'(intReq), 8'(r));
    chk(8'(intLevel), 8'(l));
    if (r)
    begin
      chk(8'(intVecIndex), 8'(i));
      chk(intVecAddr, 8'h03 + {1'b0, i, 3'h0});
    end
  endtask
  task automatic apply(input logic [17:0] e, input logic [17:0] p,
                       input logic [9:0] s);
    @(posedge clk);
    srcEnable  <= e;
    srcPending <= p;
    levelSel   <= s;
    @(posedge clk);
    @(negedge clk);
  endtask
  // one ack or return pulse through the core model
  task automatic act(input logic a, input logic [1:0] svc);
    @(posedge clk);
    ackCmd <= a;
    retCmd <= !a;
    @(posedge clk);
    ackCmd <= 1'b0;
    retCmd <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk(8'(serviceLevel), 8'(svc));
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    offer(1'b0, 4'h0, 2'h0);
    chk(intVecAddr, 8'h03);
    chk(8'(serviceLevel), 8'h00);
    reset_n <= 1'b1;
    $display("reset test done");
    foreach (Rows[k])
    begin
      apply(Rows[k].en, Rows[k].pd, Rows[k].sel);
      offer(Rows[k].req, Rows[k].idx, Rows[k].lvl);
    end
    $display("table test done");
    apply(18'h3FFFF, 18'h20000, 10'h015);
    offer(1'b1, 4'h9, 2'h1);
    act(1'b1, 2'h1);
    offer(1'b0, 4'h0, 2'h0);
    apply(18'h3FFFF, 18'h20080, 10'h015);
    offer(1'b1, 4'h4, 2'h2);
    act(1'b1, 2'h2);
    apply(18'h3FFFF, 18'h20084, 10'h015);
    offer(1'b0, 4'h0, 2'h0);
    apply(18'h3FFFF, 18'h20085, 10'h015);
    offer(1'b1, 4'h0, 2'h3);
    act(1'b1, 2'h3);
    act(1'b0, 2'h2);
    offer(1'b1, 4'h0, 2'h3);
    apply(18'h3FFFF, 18'h20004, 10'h015);
    act(1'b0, 2'h1);
    offer(1'b1, 4'h2, 2'h2);
    @(posedge clk);
    reset_n <= 1'b0;
    @(negedge clk);
    offer(1'b0, 4'h0, 2'h0);
    chk(8'(serviceLevel), 8'h00);
    $display("nesting test done");
    end_of_test();
  end
endmodule // mvip_ctrl_bench
